/* core/nvs_defines.vh */
`ifndef NVS_DEFINES_VH
`define NVS_DEFINES_VH
`define NVS_AW 11
`define NVS_DW 8
`define NVS_CLK_NS 4
// slowest speed grade timings, ns, except the settle time in us
`define NVS_T_ACC_NS 200
`define NVS_T_WP_NS 150
`define NVS_T_DS_NS 80
`define NVS_T_WC_NS 200
`define NVS_T_REC_SEL_NS 10
`define NVS_T_FLOAT_NS 35
`define NVS_T_SETTLE_US 2000
`define NVS_CNT_W 20
`define NVS_ST_IDLE 3'h0
`define NVS_ST_RD 3'h1
`define NVS_ST_WR 3'h2
`define NVS_ST_WREC 3'h3
`define NVS_ST_RREC 3'h4
`define NVS_ST_WAIT 3'h5
`endif

/* core/nvs_settle.v */
`timescale 1ns/1ns
`include "nvs_defines.vh"
// holds ready low until the supply has been good for the settle window
module nvs_settle #(
	parameter SETTLE_CYC = 500000
) (
	// clock and reset
	input wire mclk,
	input wire sys_rst,
	// supply status
	input wire supply_good,
	// result
	output reg ready
);
	reg [`NVS_CNT_W-1:0] count;
	always @(posedge mclk) begin
		if (sys_rst || !supply_good) begin
			count <= {`NVS_CNT_W{1'b0}};
			ready <= 1'b0;
		end else if (count >= SETTLE_CYC[`NVS_CNT_W-1:0] - 20'h1) begin
			ready <= 1'b1;
		end else begin
			count <= count + 20'h1;
		end
	end
endmodule // nvs_settle

/* core/nvs_host.v */
`timescale 1ns/1ns
`include "nvs_defines.vh"
// bus master for a 2048 x 8 asynchronous battery-backed memory
module nvs_host #(
	parameter SETTLE_CYC = (`NVS_T_SETTLE_US * 1000) / `NVS_CLK_NS
) (
	// clock and reset
	input wire mclk,
	input wire sys_rst,
	// user request
	input wire req_valid,
	input wire req_write,
	input wire [`NVS_AW-1:0] req_addr,
	input wire [`NVS_DW-1:0] req_wdata,
	output reg req_ready,
	output reg rsp_valid,
	output reg [`NVS_DW-1:0] rsp_rdata,
	// supply status, high while the supply is above the operating level
	input wire supply_good,
	// memory pins
	output reg [`NVS_AW-1:0] byte_address,
	input wire [`NVS_DW-1:0] data_lines_in,
	output reg [`NVS_DW-1:0] data_lines_out,
	output reg data_lines_oe,
	output reg chip_sel_n,
	output reg write_n,
	output reg out_gate_n
);
	localparam ACC_CYC = (`NVS_T_ACC_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS;
	localparam WP_CYC = (`NVS_T_WP_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS;
	localparam DS_CYC = (`NVS_T_DS_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS;
	localparam WC_CYC = (`NVS_T_WC_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS;
	localparam REC_CYC = (`NVS_T_REC_SEL_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS;
	localparam FLT_CYC = (`NVS_T_FLOAT_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS;
	localparam PULSE_CYC = (WP_CYC > DS_CYC) ? WP_CYC : DS_CYC;
	localparam WGAP_CYC = (WC_CYC - PULSE_CYC > REC_CYC) ? WC_CYC - PULSE_CYC : REC_CYC;
	localparam RGAP_CYC = (FLT_CYC > 1) ? FLT_CYC : 1;

	localparam ST_IDLE = `NVS_ST_IDLE;
	localparam ST_RD = `NVS_ST_RD;
	localparam ST_WR = `NVS_ST_WR;
	localparam ST_WREC = `NVS_ST_WREC;
	localparam ST_RREC = `NVS_ST_RREC;
	localparam ST_WAIT = `NVS_ST_WAIT;

	// sequencer state and its step counter
	reg [2:0] state;
	reg [2:0] next_state;
	reg [7:0] timer;
	reg [7:0] next_timer;
	// one-cycle events decoded from the current state
	reg go_read;
	reg go_write;
	reg read_done;
	reg write_done;
	reg gap_done;
	reg wake;
	reg abort;
	wire settled;

	////////////////////////////////////////////////////////////////////////////
	nvs_settle #(
		.SETTLE_CYC(SETTLE_CYC)
	) u_settle (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.supply_good(supply_good),
		.ready(settled)
	);

	////////////////////////////////////////////////////////////////////////////
	// next state and one-cycle event decode
	always @* begin
		next_state = state;
		next_timer = timer + 8'h1;
		go_read = 1'b0;
		go_write = 1'b0;
		read_done = 1'b0;
		write_done = 1'b0;
		gap_done = 1'b0;
		wake = 1'b0;
		abort = 1'b0;
		if (state != ST_WAIT && !supply_good) begin
			// supply sagging: drop any access, deselect and restart the settle wait
			abort = 1'b1;
			next_state = ST_WAIT;
			next_timer = 8'h0;
		end else begin
			case (state)
			ST_WAIT: begin
				next_timer = 8'h0;
				if (settled && supply_good) begin
					wake = 1'b1;
					next_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				next_timer = 8'h0;
				if (req_valid) begin
					go_write = req_write;
					go_read = !req_write;
					if (req_write)
						next_state = ST_WR;
					else
						next_state = ST_RD;
				end
			end
			ST_RD: begin
				// timed from select and gate, both asserted at cycle 0
				if (timer == ACC_CYC[7:0]) begin
					read_done = 1'b1;
					next_timer = 8'h0;
					next_state = ST_RREC;
				end
			end
			ST_WR: begin
				// address and data held steady across the whole pulse
				if (timer == PULSE_CYC[7:0]) begin
					write_done = 1'b1;
					next_timer = 8'h0;
					next_state = ST_WREC;
				end
			end
			ST_WREC: begin
				// strobe stays high for recovery before the next cycle
				if (timer == WGAP_CYC[7:0]) begin
					gap_done = 1'b1;
					next_state = ST_IDLE;
				end
			end
			ST_RREC: begin
				// let device drivers float before the next cycle
				if (timer == RGAP_CYC[7:0]) begin
					gap_done = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_WAIT;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer registers
	always @(posedge mclk) begin
		if (sys_rst) begin
			state <= ST_WAIT;
			timer <= 8'h0;
		end else begin
			state <= next_state;
			timer <= next_timer;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// address and write data
	always @(posedge mclk) begin
		if (sys_rst) begin
			byte_address <= {`NVS_AW{1'b0}};
			data_lines_out <= {`NVS_DW{1'b0}};
			data_lines_oe <= 1'b0;
		end else if (abort || state == ST_WAIT) begin
			data_lines_oe <= 1'b0;
		end else if (go_write || go_read) begin
			byte_address <= req_addr;
			data_lines_oe <= go_write;
			if (go_write)
				data_lines_out <= req_wdata;
		end else if (gap_done) begin
			// data held past select rising until the recovery gap ends
			data_lines_oe <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus strobes
	always @(posedge mclk) begin
		if (sys_rst) begin
			chip_sel_n <= 1'b1;
			write_n <= 1'b1;
			out_gate_n <= 1'b1;
		end else if (abort || state == ST_WAIT) begin
			// select held high through power-down and power-up settle
			chip_sel_n <= 1'b1;
			write_n <= 1'b1;
			out_gate_n <= 1'b1;
		end else if (go_write) begin
			// strobe and select fall together, gate kept high
			chip_sel_n <= 1'b0;
			write_n <= 1'b0;
			out_gate_n <= 1'b1;
		end else if (go_read) begin
			chip_sel_n <= 1'b0;
			write_n <= 1'b1;
			out_gate_n <= 1'b0;
		end else if (write_done || read_done) begin
			// select and strobe rise together, so select ends the write
			chip_sel_n <= 1'b1;
			write_n <= 1'b1;
			out_gate_n <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// user handshake
	always @(posedge mclk) begin
		if (sys_rst) begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= {`NVS_DW{1'b0}};
		end else begin
			rsp_valid <= read_done;
			if (read_done)
				rsp_rdata <= data_lines_in;
			if (abort || go_read || go_write)
				req_ready <= 1'b0;
			else if (wake || gap_done)
				req_ready <= 1'b1;
		end
	end
endmodule // nvs_host

/* test/nvs_mem_model.sv */
`timescale 1ns/1ns
module nvs_mem_model(
	// memory pins
	input wire logic [10:0] byte_address,
	input wire logic chip_sel_n,
	input wire logic write_n,
	input wire logic out_gate_n,
	input wire logic [7:0] bus,
	input wire logic pwr_ok,
	// device drive
	output logic [7:0] q,
	output logic q_en
);
	logic [7:0] mem [0:2047];
	logic [10:0] pa;
	logic [7:0] pd;
	wire act = pwr_ok && !chip_sel_n && !write_n;
	assign q_en = pwr_ok && !chip_sel_n && !out_gate_n && write_n;
	// undriven bus shows the inverse rather than a stale byte
	assign q = q_en ? mem[byte_address] : ~mem[byte_address];
	always @* if (act) begin
		pa = byte_address;
		pd = bus;
	end
	always @(negedge act) if (pwr_ok) mem[pa] = pd;
endmodule // nvs_mem_model

/* test/nvs_host_sva.sv */
`timescale 1ns/1ns
module nvs_host_sva(
	// watched ports
	input wire mclk,
	input wire sys_rst,
	input wire req_valid,
	input wire req_write,
	input wire req_ready,
	input wire rsp_valid,
	input wire supply_good,
	input wire [10:0] byte_address,
	input wire data_lines_oe,
	input wire chip_sel_n,
	input wire write_n,
	input wire out_gate_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_read_strobes: assert property (!chip_sel_n && !out_gate_n |-> write_n)
		else $error("gate and strobe low");
	a_gate_quiet: assert property (data_lines_oe |-> out_gate_n)
		else $error("gate low while driving");
	a_addr_held: assert property (!chip_sel_n && !write_n && $past(!write_n) |-> $stable(byte_address))
		else $error("address moved in write");
	a_pulse_width: assert property ($fell(write_n) |-> !chip_sel_n ##37 !write_n)
		else $error("write pulse short");
	a_data_hold: assert property ($rose(chip_sel_n) && $past(!write_n) |-> data_lines_oe[*3])
		else $error("data hold short");
	a_recovery: assert property ($rose(write_n) |-> write_n[*8])
		else $error("recovery short");
	a_read_latency: assert property (req_valid && req_ready && !req_write |-> ##52 rsp_valid)
		else $error("read answer late");
	a_select_idle: assert property (chip_sel_n |-> write_n && out_gate_n)
		else $error("strobe without select");
	a_settle_wait: assert property ($rose(supply_good) |-> !req_ready[*8])
		else $error("ready before settle");
endmodule // nvs_host_sva
bind nvs_host nvs_host_sva i_sva(.mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid),
	.req_write(req_write), .req_ready(req_ready), .rsp_valid(rsp_valid),
	.supply_good(supply_good), .byte_address(byte_address), .data_lines_oe(data_lines_oe),
	.chip_sel_n(chip_sel_n), .write_n(write_n), .out_gate_n(out_gate_n));

/* test/tb_top.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
	logic mclk = 0, sys_rst = 1, req_valid = 0, req_write = 0, supply_good = 1;
	logic [10:0] req_addr = 0, byte_address;
	logic [7:0] req_wdata = 0, rsp_rdata, data_lines_out, q;
	logic req_ready, rsp_valid, data_lines_oe, chip_sel_n, write_n, out_gate_n, q_en;
	wire [7:0] dq = data_lines_oe ? data_lines_out : q;
	int bad_count = 0, comparisons = 0;
	nvs_host #(.SETTLE_CYC(20)) i_nvs_host(.mclk(mclk), .sys_rst(sys_rst),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .supply_good(supply_good), .byte_address(byte_address),
		.data_lines_in(dq), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
		.chip_sel_n(chip_sel_n), .write_n(write_n), .out_gate_n(out_gate_n));
	nvs_mem_model i_mem(.byte_address(byte_address), .chip_sel_n(chip_sel_n),
		.write_n(write_n), .out_gate_n(out_gate_n), .bus(dq), .pwr_ok(supply_good),
		.q(q), .q_en(q_en));
	initial forever #2 mclk = ~mclk;
	always @(negedge mclk) if (data_lines_oe === 1'b1) `CHK(q_en, 1'b0)
	task automatic xfer(input logic w, input logic [10:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 300) begin
			@(negedge mclk);
			n++;
		end
		`CHK(req_ready, 1'b1)
		req_valid = 1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		@(negedge mclk);
		req_valid = 0;
		n = 1;
		while (!w && rsp_valid !== 1'b1 && n < 100) begin
			@(negedge mclk);
			n++;
		end
		if (!w) `CHK(n, 52)
		if (!w) `CHK(rsp_rdata, d)
	endtask
	task automatic t_write_read;
		xfer(1, 11'h000, 8'h5a);
		xfer(1, 11'h7ff, 8'ha5);
		xfer(1, 11'h7ff, 8'h3c);
		xfer(1, 11'h400, 8'hc3);
		xfer(0, 11'h000, 8'h5a);
		xfer(0, 11'h7ff, 8'h3c);
		xfer(0, 11'h400, 8'hc3);
	endtask
	task automatic t_protect;
		@(negedge mclk);
		supply_good = 0;
		@(negedge mclk);
		`CHK(req_ready, 1'b0)
		`CHK(chip_sel_n, 1'b1)
		`CHK(q_en, 1'b0)
		supply_good = 1;
		repeat (10) @(negedge mclk);
		`CHK(req_ready, 1'b0)
		xfer(0, 11'h7ff, 8'h3c);
	endtask
	task automatic give_verdict;
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		give_verdict();
	end
	initial begin
		repeat (12) @(negedge mclk);
		sys_rst = 0;
		t_write_read();
		t_protect();
		give_verdict();
	end
endmodule // tb_top
